// ==== cirq_chk.sv ====
// port assertions for the can interrupt flag logic
`timescale 1ns/1ps
module cirq_chk (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [2:0] irq_request_bit
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   logic acc;
   logic mapped;
   assign acc = psel && penable;
   assign mapped = paddr <= cirq_pkg::OFF_MODE && paddr[1:0] == 2'h0;
   zero_wait_a: assert property (acc |-> pready) else $error("pready low in access");
   err_unmapped_a: assert property (acc && paddr > cirq_pkg::OFF_MODE |-> pslverr)
      else $error("no error on unmapped address");
   err_mapped_a: assert property (acc && mapped |-> !pslverr) else $error("error on mapped address");
   err_idle_a: assert property (!acc |-> !pslverr) else $error("error outside access phase");
   rd_unmapped_a: assert property (acc && !pwrite && paddr > cirq_pkg::OFF_MODE |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   req_hold_a: assert property (acc && pwrite && paddr == cirq_pkg::OFF_REQ && !pwdata[2]
      && irq_request_bit[2] |=> (!irq_request_bit[2]) [*5]) else $error("request hold wrong");
   req_read_a: assert property (acc && !pwrite && paddr == cirq_pkg::OFF_REQ
      |-> prdata[2:0] == irq_request_bit) else $error("request read differs");
   req_reset_a: assert property ($rose(nrst) |-> (irq_request_bit == 3'h0) [*2])
      else $error("request set after reset");
endmodule
bind cirq_top cirq_chk chk (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .irq_request_bit(irq_request_bit));

// ==== cirq_mb_flags.sv ====
// per-mailbox fresh and sent message flag store
`timescale 1ns/1ps
module cirq_mb_flags (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [15:0] fresh_set,
   input wire logic [15:0] sent_set,
   input wire logic [15:0] fresh_clr,
   input wire logic [15:0] sent_clr,
   output logic [15:0] fresh_r,
   output logic [15:0] sent_r
);
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_mb
         // R15 set beats clear
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               fresh_r[gi] <= 1'b0;
               sent_r[gi] <= 1'b0;
            end else begin
               if (fresh_set[gi])
                  fresh_r[gi] <= 1'b1;
               else if (fresh_clr[gi])
                  fresh_r[gi] <= 1'b0;
               if (sent_set[gi])
                  sent_r[gi] <= 1'b1;
               else if (sent_clr[gi])
                  sent_r[gi] <= 1'b0;
            end
         end
      end
   endgenerate
endmodule

// ==== cirq_pkg.sv ====
// constants, register map and field layout of the can interrupt flag logic
// Overview of operation
// R1: reset or can reset mode clears queue/error flags
// R2: write zero clears flag only after read one
// R3: wake flag ignores can reset mode entry
// R4: summary flags read-only, cleared by reset/mode
// R5: rx summary is OR of enabled fresh flags
// R6: tx summary is OR of enabled sent flags
// R7: disabled mailbox contributes no request
// R8: software clears every enabled fresh flag
// R9: software clears every enabled sent flag
// R10: shared request drops only when both zero; code also drops it while the R13 hold count runs
// R11: three request bits, each shared by two sources
// R12: request follows enabled flags, never latches
// R13: written-zero request returns after five cycles
// R14: falling edge on can receive sets wake flag
// R15: hardware set wins over same-cycle clear
package cirq_pkg;
   localparam int NUM_MB = 16;
   // register byte offsets
   localparam logic [11:0] OFF_STATUS = 12'h000;
   localparam logic [11:0] OFF_SRC_EN = 12'h004;
   localparam logic [11:0] OFF_MB_EN = 12'h008;
   localparam logic [11:0] OFF_FRESH = 12'h00C;
   localparam logic [11:0] OFF_SENT = 12'h010;
   localparam logic [11:0] OFF_REQ = 12'h014;
   localparam logic [11:0] OFF_MODE = 12'h018;
   // status bit positions
   localparam int B_RXQ = 0;
   localparam int B_TXQ = 1;
   localparam int B_ERR = 2;
   localparam int B_WAKE = 3;
   localparam int B_RXD = 4;
   localparam int B_TXD = 5;
   localparam int NUM_SRC = 6;
   localparam int NUM_REQ = 3;
   localparam logic [5:0] SRC_EN_RST = 6'h00;
   localparam logic [15:0] MB_EN_RST = 16'h0000;
   // request hold-off after a written zero, in ns and cycles
   localparam int CLK_NS = 10;
   localparam int REQ_HOLD_NS = 50;
   localparam int REQ_HOLD_CYC = (REQ_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int HOLD_W = 3;
   typedef enum logic [1:0] {
      CIRQ_MODE_OPER = 2'b00,
      CIRQ_MODE_RESET = 2'b01,
      CIRQ_MODE_HALT = 2'b10
   } cirq_mode_t;
endpackage

// ==== cirq_top.sv ====
// can interrupt status, flag clearing and shared request logic with apb slave
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module cirq_top (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic can_rx,
   input wire logic rxq_event,
   input wire logic txq_event,
   input wire logic err_event,
   input wire logic [15:0] mb_rx_event,
   input wire logic [15:0] mb_tx_event,
   output logic [2:0] irq_request_bit
);
   logic rst_s1_r;
   logic rst_n;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n <= rst_s1_r;
      end
   end

   logic wr_acc;
   logic rd_acc;
   logic [5:0] status;
   logic [3:0] flag_r;
   logic [3:0] seen_one_r;
   logic [5:0] src_en_r;
   logic [15:0] mailbox_irq_enable_reg;
   logic [15:0] mailbox_fresh_msg_flag;
   logic [15:0] mailbox_sent_msg_flag;
   logic [15:0] fresh_clr;
   logic [15:0] sent_clr;
   cirq_pkg::cirq_mode_t mode_r;
   logic mode_rst_prev_r;
   logic enter_reset;
   logic can_rx_prev_r;
   logic rx_fall;
   logic rx_done_summary_flag;
   logic tx_done_summary_flag;
   logic rxd_gate_r;
   logic txd_gate_r;
   logic [3:0] hw_set;
   logic [2:0] req_raw;
   logic [cirq_pkg::HOLD_W-1:0] hold_r [3];
   logic [31:0] rd_nxt;

   assign pready = 1'b1;
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;

   // mode register; entry into can reset mode is a one-cycle event
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_r <= cirq_pkg::CIRQ_MODE_RESET;
         mode_rst_prev_r <= 1'b1;
      end else begin
         if (wr_acc && paddr == cirq_pkg::OFF_MODE)
            mode_r <= cirq_pkg::cirq_mode_t'(pwdata[1:0]);
         mode_rst_prev_r <= (mode_r == cirq_pkg::CIRQ_MODE_RESET);
      end
   end
   assign enter_reset = (mode_r == cirq_pkg::CIRQ_MODE_RESET) && !mode_rst_prev_r;

   // R14 falling edge of can receive
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         can_rx_prev_r <= 1'b1;
      else
         can_rx_prev_r <= can_rx;
   end
   assign rx_fall = can_rx_prev_r && !can_rx;
   assign hw_set = {rx_fall, err_event, txq_event, rxq_event};

   // enable registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         src_en_r <= cirq_pkg::SRC_EN_RST;
         mailbox_irq_enable_reg <= cirq_pkg::MB_EN_RST;
      end else if (wr_acc) begin
         if (paddr == cirq_pkg::OFF_SRC_EN)
            src_en_r <= pwdata[5:0];
         else if (paddr == cirq_pkg::OFF_MB_EN)
            mailbox_irq_enable_reg <= pwdata[15:0];
      end
   end

   // software-clearable status flags with read-one tracking
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_flag
         logic clr_wr;
         assign clr_wr = wr_acc && paddr == cirq_pkg::OFF_STATUS && !pwdata[gi];
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               flag_r[gi] <= 1'b0;
               seen_one_r[gi] <= 1'b0;
            end else begin
               // R15 hardware set wins
               if (hw_set[gi])
                  flag_r[gi] <= 1'b1;
               // R1 R3 mode entry spares the wake flag
               else if (enter_reset && gi != cirq_pkg::B_WAKE)
                  flag_r[gi] <= 1'b0;
               // R2 zero clears only after one was read
               else if (clr_wr && seen_one_r[gi])
                  flag_r[gi] <= 1'b0;
               if (rd_acc && paddr == cirq_pkg::OFF_STATUS && flag_r[gi])
                  seen_one_r[gi] <= 1'b1;
               else if (clr_wr || !flag_r[gi])
                  seen_one_r[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // R8 R9 software clears mailbox flags by writing ones
   assign fresh_clr = (wr_acc && paddr == cirq_pkg::OFF_FRESH) ? pwdata[15:0] : 16'h0000;
   assign sent_clr = (wr_acc && paddr == cirq_pkg::OFF_SENT) ? pwdata[15:0] : 16'h0000;

   cirq_mb_flags u_mb (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .fresh_set(mb_rx_event),
      .sent_set(mb_tx_event),
      .fresh_clr(fresh_clr),
      .sent_clr(sent_clr),
      .fresh_r(mailbox_fresh_msg_flag),
      .sent_r(mailbox_sent_msg_flag)
   );

   // R4 summaries blanked after mode entry until a new mailbox event
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rxd_gate_r <= 1'b0;
         txd_gate_r <= 1'b0;
      end else begin
         if (|mb_rx_event)
            rxd_gate_r <= 1'b1;
         else if (enter_reset)
            rxd_gate_r <= 1'b0;
         if (|mb_tx_event)
            txd_gate_r <= 1'b1;
         else if (enter_reset)
            txd_gate_r <= 1'b0;
      end
   end
   // R5 R7 rx summary over enabled mailboxes
   assign rx_done_summary_flag = rxd_gate_r && |(mailbox_fresh_msg_flag & mailbox_irq_enable_reg);
   // R6 R7 tx summary over enabled mailboxes
   assign tx_done_summary_flag = txd_gate_r && |(mailbox_sent_msg_flag & mailbox_irq_enable_reg);

   assign status = {tx_done_summary_flag, rx_done_summary_flag, flag_r};

   // R11 R12 sources paired onto three level requests
   assign req_raw[0] = (status[cirq_pkg::B_RXD] && src_en_r[cirq_pkg::B_RXD])
                     || (status[cirq_pkg::B_RXQ] && src_en_r[cirq_pkg::B_RXQ]);
   assign req_raw[1] = (status[cirq_pkg::B_TXD] && src_en_r[cirq_pkg::B_TXD])
                     || (status[cirq_pkg::B_TXQ] && src_en_r[cirq_pkg::B_TXQ]);
   assign req_raw[2] = (status[cirq_pkg::B_ERR] && src_en_r[cirq_pkg::B_ERR])
                     || (status[cirq_pkg::B_WAKE] && src_en_r[cirq_pkg::B_WAKE]);

   generate
      for (gi = 0; gi < cirq_pkg::NUM_REQ; gi++) begin : g_req
         // R13 written zero drops the request for the hold time
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n)
               hold_r[gi] <= '0;
            else if (wr_acc && paddr == cirq_pkg::OFF_REQ && !pwdata[gi])
               hold_r[gi] <= cirq_pkg::HOLD_W'(cirq_pkg::REQ_HOLD_CYC);
            else if (hold_r[gi] != '0)
               hold_r[gi] <= hold_r[gi] - 1'b1;
         end
         // R10 request stays while either paired source is pending and its hold count is zero
         assign irq_request_bit[gi] = req_raw[gi] && (hold_r[gi] == '0);
      end
   endgenerate

   // read mux
   always_comb begin
      rd_nxt = 32'h0000_0000;
      pslverr = 1'b0;
      if (paddr == cirq_pkg::OFF_STATUS)
         rd_nxt = {26'h0, status};
      else if (paddr == cirq_pkg::OFF_SRC_EN)
         rd_nxt = {26'h0, src_en_r};
      else if (paddr == cirq_pkg::OFF_MB_EN)
         rd_nxt = {16'h0, mailbox_irq_enable_reg};
      else if (paddr == cirq_pkg::OFF_FRESH)
         rd_nxt = {16'h0, mailbox_fresh_msg_flag};
      else if (paddr == cirq_pkg::OFF_SENT)
         rd_nxt = {16'h0, mailbox_sent_msg_flag};
      else if (paddr == cirq_pkg::OFF_REQ)
         rd_nxt = {29'h0, irq_request_bit};
      else if (paddr == cirq_pkg::OFF_MODE)
         rd_nxt = {30'h0, mode_r};
      else
         pslverr = psel && penable;
   end
   assign prdata = rd_nxt;
endmodule

// ==== cirq_top_test.sv ====
// self-checking bench for the can interrupt flag logic
`timescale 1ns/1ps
module cirq_top_test;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, can_rx = 1'b1;
   logic rxq_event = 1'b0, txq_event = 1'b0, err_event = 1'b0;
   logic [15:0] mb_rx_event = 16'h0000, mb_tx_event = 16'h0000;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err;
   logic [2:0] irq_request_bit;
   int mismatches = 0, checks = 0;
   always #5 core_clk = ~core_clk;
   cirq_top uut (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .can_rx(can_rx), .rxq_event(rxq_event), .txq_event(txq_event),
      .err_event(err_event), .mb_rx_event(mb_rx_event), .mb_tx_event(mb_tx_event),
      .irq_request_bit(irq_request_bit));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   task automatic pulse(input logic [34:0] v);
      @(posedge core_clk);
      {rxq_event, txq_event, err_event, mb_rx_event, mb_tx_event} <= v;
      @(posedge core_clk);
      {rxq_event, txq_event, err_event, mb_rx_event, mb_tx_event} <= 35'h0;
      #1;
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      #50000;
      mismatches++;
      end_sim();
   end
   initial begin
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge core_clk);
      xfer(1'b0, cirq_pkg::OFF_STATUS, 32'h0);
      chk(rd, 32'h0);
      chk(32'(irq_request_bit), 32'h0);
      xfer(1'b0, cirq_pkg::OFF_MODE, 32'h0);
      chk(rd, 32'h1);
      xfer(1'b1, cirq_pkg::OFF_MODE, 32'h0);
      xfer(1'b1, cirq_pkg::OFF_SRC_EN, 32'h3F);
      xfer(1'b1, cirq_pkg::OFF_MB_EN, 32'h1);
      pulse(35'h400000000);
      chk(32'(irq_request_bit), 32'h1);
      xfer(1'b1, cirq_pkg::OFF_STATUS, 32'h0);
      xfer(1'b0, cirq_pkg::OFF_STATUS, 32'h0);
      chk(rd, 32'h1);
      xfer(1'b1, cirq_pkg::OFF_STATUS, 32'h0);
      chk(32'(irq_request_bit), 32'h0);
      pulse(35'h400010000);
      xfer(1'b0, cirq_pkg::OFF_STATUS, 32'h0);
      chk(rd, 32'h11);
      xfer(1'b1, cirq_pkg::OFF_STATUS, 32'h0);
      chk(32'(irq_request_bit), 32'h1);
      xfer(1'b1, cirq_pkg::OFF_FRESH, 32'h1);
      chk(32'(irq_request_bit), 32'h0);
      pulse(35'h000020000);
      chk(32'(irq_request_bit), 32'h0);
      pulse(35'h000000001);
      chk(32'(irq_request_bit), 32'h2);
      xfer(1'b1, cirq_pkg::OFF_SENT, 32'h1);
      chk(32'(irq_request_bit), 32'h0);
      @(posedge core_clk);
      can_rx <= 1'b0;
      repeat (2) @(posedge core_clk);
      can_rx <= 1'b1;
      #1;
      chk(32'(irq_request_bit), 32'h4);
      pulse(35'h700000001);
      chk(32'(irq_request_bit), 32'h7);
      xfer(1'b1, cirq_pkg::OFF_MODE, 32'h1);
      xfer(1'b0, cirq_pkg::OFF_STATUS, 32'h0);
      chk(rd, 32'h8);
      xfer(1'b1, cirq_pkg::OFF_MODE, 32'h0);
      xfer(1'b1, cirq_pkg::OFF_REQ, 32'h0);
      chk(32'(irq_request_bit), 32'h0);
      repeat (6) @(posedge core_clk);
      #1;
      chk(32'(irq_request_bit), 32'h4);
      xfer(1'b1, cirq_pkg::OFF_STATUS, 32'h0);
      xfer(1'b0, cirq_pkg::OFF_STATUS, 32'h0);
      xfer(1'b1, cirq_pkg::OFF_STATUS, 32'h0);
      chk(32'(irq_request_bit), 32'h0);
      pulse(35'h400000000);
      xfer(1'b0, cirq_pkg::OFF_STATUS, 32'h0);
      // set event lands on the clearing write edge
      fork
         xfer(1'b1, cirq_pkg::OFF_STATUS, 32'h0);
         begin
            repeat (2) @(posedge core_clk);
            rxq_event <= 1'b1;
            @(posedge core_clk);
            rxq_event <= 1'b0;
         end
      join
      xfer(1'b0, cirq_pkg::OFF_STATUS, 32'h0);
      chk(rd, 32'h1);
      xfer(1'b0, cirq_pkg::OFF_REQ, 32'h0);
      chk(rd, 32'h1);
      chk(32'(err), 32'h0);
      xfer(1'b1, 12'h01C, 32'hFFFFFFFF);
      chk(32'(err), 32'h1);
      xfer(1'b0, 12'h01C, 32'h0);
      chk(rd, 32'h0);
      chk(32'(err), 32'h1);
      end_sim();
   end
endmodule
